/* File: hdl/ctpr_pkg.sv */
/*
 Shared constants and carrier types for the two-port RAM: clocking modes,
 register offsets, control fields and reset values.
 Assumes a 32-bit APB register port with a 12-bit byte address.
*/
package ctpr_pkg;

   typedef enum {
      CLK_SINGLE,
      CLK_IN_OUT,
      CLK_RD_WR,
      CLK_PORT_AB
   } ctpr_clk_mode_t;

   // Software controls that steer the read path and the encoder.
   typedef struct packed {
      logic enc_bypass;
      logic force_zero;
      logic rdw_new;
   } ctpr_ctrl_t;

   localparam int APB_AW = 12;
   localparam int CTRL_W = 3;
   localparam logic [APB_AW-1:0] CTRL_OFS = 12'h000;
   localparam logic [APB_AW-1:0] STAT_OFS = 12'h004;
   localparam ctpr_ctrl_t CTRL_RST = 3'h0;
   localparam int STAT_CORR = 0;
   localparam int STAT_UNCORR = 1;
   localparam logic [1:0] STAT_RST = 2'h0;

   localparam int SLICE_LOGIC = 32;
   localparam int SLICE_BLK_S = 512;
   localparam int SLICE_BLK_M = 1024;
   localparam int SLICE_BLK_L = 2048;

endpackage

/* File: hdl/ctpr_ram.sv */
/*
 Configurable two-port RAM with optional byte enables, mixed port widths,
 per-group input and output registers, address stalls, clears, ECC with
 optional pipeline and encoder bypass, coherent read and an APB control port.
 Assumes one clock; the other clocking modes become enable groups.
*/
// Functional notes
// - Simple dual-port or two read/write ports.
// - Port B width may equal or double port A width.
// - Slice depth 32, 512, 1024 or 2048.
// - Single mode: one enable governs everything.
// - In/out mode: input and output enables.
// - Read/write mode: write and read enables.
// - Per-port mode: independent A and B enables.
// - Optional read enable per read port.
// - Byte enables mask unselected write bytes.
// - Port B byte enable only two-port.
// - Byte width 5/10 or 8/9/10.
// - ECC corrects adjacent errors, detects more.
// - ECC pipeline adds one read cycle.
// - Encoder bypass stores supplied check bits.
// - Coherent read allows same-cycle modify-write.
// - Each register group individually selectable.
// - Separate enables for input and output.
// - Address stall holds the address register.
// - Async clear resets port B address and outputs.
// - Sync clear resets data outputs.
// - Mixed-port collision shows new or old.
// - Force-to-zero blanks output without read.
`timescale 1ns/1ns
module ctpr_ram #(
   parameter bit TRUE_TWO_PORT = 1'b0,
   parameter int A_W = 16,
   parameter int B_W = 16,
   parameter int DEPTH = 256,
   parameter int SLICE_DEPTH = 512,
   parameter int BYTE_W = 8,
   parameter bit BE_A_EN = 1'b1,
   parameter bit BE_B_EN = 1'b0,
   parameter bit RDEN_EN = 1'b1,
   parameter bit ECC_EN = 1'b0,
   parameter bit ECC_PIPE = 1'b0,
   parameter bit ENC_BYPASS_EN = 1'b0,
   parameter bit COHERENT_EN = 1'b0,
   parameter bit REG_WR_IN = 1'b1,
   parameter bit REG_RADDR = 1'b1,
   parameter bit REG_QA = 1'b1,
   parameter bit REG_QB = 1'b1,
   parameter bit ADDR_STALL_EN = 1'b1,
   parameter bit ACLR_EN = 1'b1,
   parameter bit SCLR_EN = 1'b1,
   parameter ctpr_pkg::ctpr_clk_mode_t CLK_MODE = ctpr_pkg::CLK_SINGLE
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic aclr_i,
   input wire logic sclr_i,
   input wire logic clken_a_in_i,
   input wire logic clken_a_out_i,
   input wire logic clken_b_in_i,
   input wire logic clken_b_out_i,
   input wire logic addr_stall_a_i,
   input wire logic addr_stall_b_i,
   input wire logic [$clog2(DEPTH)-1:0] addr_a_i,
   input wire logic [A_W-1:0] data_a_i,
   input wire logic we_a_i,
   input wire logic [A_W/BYTE_W-1:0] be_a_i,
   input wire logic rden_a_i,
   input wire logic [2*A_W-1:0] ecc_chk_a_i,
   output logic [A_W-1:0] q_a_o,
   output logic [A_W-1:0] coh_q_a_o,
   input wire logic [$clog2(DEPTH*A_W/B_W)-1:0] addr_b_i,
   input wire logic [B_W-1:0] data_b_i,
   input wire logic we_b_i,
   input wire logic [B_W/BYTE_W-1:0] be_b_i,
   input wire logic rden_b_i,
   output logic [B_W-1:0] q_b_o,
   output logic ecc_corr_o,
   output logic ecc_uncorr_o,
   input wire logic [ctpr_pkg::APB_AW-1:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o
);

   localparam int RATIO = B_W / A_W;
   localparam int AAW = $clog2(DEPTH);
   localparam int BAW = $clog2(DEPTH / RATIO);
   localparam int NBA = A_W / BYTE_W;
   localparam int NBB = B_W / BYTE_W;
   localparam int CHK_W = 2 * A_W;
   localparam int CW = ECC_EN ? 3 * A_W : A_W;
   localparam int CWB = ECC_EN ? 3 * A_W : B_W;
   localparam int SLICES = (DEPTH + SLICE_DEPTH - 1) / SLICE_DEPTH;

   if (!(SLICE_DEPTH == ctpr_pkg::SLICE_LOGIC || SLICE_DEPTH == ctpr_pkg::SLICE_BLK_S ||
         SLICE_DEPTH == ctpr_pkg::SLICE_BLK_M || SLICE_DEPTH == ctpr_pkg::SLICE_BLK_L) ||
       SLICES < 1) begin : g_bad_slice
      $error("Slice depth must be 32, 512, 1024 or 2048.");
   end
   if ((SLICE_DEPTH == ctpr_pkg::SLICE_LOGIC) ? !(BYTE_W == 5 || BYTE_W == 10)
       : !(BYTE_W == 8 || BYTE_W == 9 || BYTE_W == 10)) begin : g_bad_byte
      $error("Byte width does not suit the slice kind.");
   end
   if (!(B_W == A_W || B_W == 2 * A_W) || A_W % BYTE_W != 0 ||
       DEPTH < 2 * RATIO || DEPTH % RATIO != 0) begin : g_bad_width
      $error("Widths must be byte multiples with port ratio 1 or 2.");
   end
   if ((ECC_PIPE && !(ECC_EN && REG_QB)) || (ECC_EN && (RATIO != 1 || BE_A_EN || BE_B_EN))
       || (BE_B_EN && !TRUE_TWO_PORT)) begin : g_bad_ecc
      $error("Illegal ECC, pipeline or port B byte enable combination.");
   end

   typedef struct packed {
      logic [AAW-1:0] addr;
      logic [A_W-1:0] din;
      logic we;
      logic [NBA-1:0] be;
      logic [CHK_W-1:0] chk;
      logic rden;
   } ctpr_a_in_t;

   typedef struct packed {
      logic [BAW-1:0] addr;
      logic [B_W-1:0] din;
      logic we;
      logic [NBB-1:0] be;
      logic rden;
   } ctpr_b_in_t;

   typedef struct packed {
      ctpr_a_in_t a_in;
      ctpr_pkg::ctpr_ctrl_t ctrl;
      logic [1:0] stat;
      logic [31:0] prdata;
   } ctpr_state_t;

   // Registers that the asynchronous clear may reach.
   typedef struct packed {
      ctpr_b_in_t b_in;
      logic [A_W-1:0] q_a;
      logic [B_W-1:0] q_b;
      logic corr;
      logic uncorr;
      logic [CWB-1:0] pipe;
      logic pipe_rden;
   } ctpr_clr_t;

   logic [CW-1:0] mem [DEPTH];
   ctpr_state_t s_r, s_nxt;
   ctpr_clr_t c_r, c_nxt;
   ctpr_a_in_t a_live, wa;
   ctpr_b_in_t b_live, wb;
   logic ea_in, eb_in, ea_out, eb_out, arst_n, byp, fz;
   logic [CW-1:0] qa_word;
   logic [A_W-1:0] qa_pre;
   logic [CWB-1:0] rb_cw, dec_in;
   logic [A_W+1:0] dx;
   logic [B_W-1:0] qb_pre;
   logic rden_dec, dcorr, duncorr;
   logic hit_ctrl, hit_stat, apb_wr;

   // Merges one write into a stored word; ECC words are always written whole.
   function automatic logic [CW-1:0] wr_word(input logic [CW-1:0] old,
         input logic [A_W-1:0] d, input logic [NBA-1:0] be,
         input logic [CHK_W-1:0] chk, input logic bp);
      logic [CW-1:0] w;
      w = old;
      for (int i = 0; i < NBA; i++) begin
         if (be[i]) begin
            w[i*BYTE_W +: BYTE_W] = d[i*BYTE_W +: BYTE_W];
         end
      end
      if (ECC_EN) begin
         w = CW'({(bp ? chk : {d, d}), d});
      end
      return w;
   endfunction

   function automatic logic [AAW-1:0] lane(input logic [BAW-1:0] a, input int k);
      return AAW'(int'(a) * RATIO + k);
   endfunction

   // Three stored copies vote bitwise, so any burst inside one copy is repaired.
   function automatic logic [A_W+1:0] ecc_dec(input logic [3*A_W-1:0] x);
      logic [A_W-1:0] d0, d1, d2;
      d0 = x[A_W-1:0];
      d1 = x[2*A_W-1:A_W];
      d2 = x[3*A_W-1:2*A_W];
      return {(d0 != d1) && (d0 != d2) && (d1 != d2), (d0 != d1) || (d0 != d2),
              (d0 & d1) | (d0 & d2) | (d1 & d2)};
   endfunction

   always_comb begin
      unique case (CLK_MODE)
         ctpr_pkg::CLK_SINGLE: begin
            ea_in = clken_a_in_i;
            eb_in = clken_a_in_i;
            ea_out = clken_a_in_i;
            eb_out = clken_a_in_i;
         end
         ctpr_pkg::CLK_IN_OUT: begin
            ea_in = clken_a_in_i;
            eb_in = clken_a_in_i;
            ea_out = clken_a_out_i;
            eb_out = clken_a_out_i;
         end
         ctpr_pkg::CLK_RD_WR, ctpr_pkg::CLK_PORT_AB: begin
            ea_in = clken_a_in_i;
            eb_in = clken_b_in_i;
            ea_out = clken_a_out_i;
            eb_out = clken_b_out_i;
         end
      endcase
   end

   assign arst_n = rst_n_i & ~(ACLR_EN & aclr_i);
   assign byp = ENC_BYPASS_EN & s_r.ctrl.enc_bypass;
   assign fz = s_r.ctrl.force_zero;

   always_comb begin
      a_live = '{addr: addr_a_i, din: data_a_i, we: we_a_i,
                 be: BE_A_EN ? be_a_i : {NBA{1'b1}}, chk: ecc_chk_a_i,
                 rden: RDEN_EN ? (TRUE_TWO_PORT & rden_a_i) : TRUE_TWO_PORT};
      b_live = '{addr: addr_b_i, din: data_b_i, we: TRUE_TWO_PORT & we_b_i,
                 be: (BE_B_EN && TRUE_TWO_PORT) ? be_b_i : {NBB{1'b1}},
                 rden: RDEN_EN ? rden_b_i : 1'b1};
      wa = REG_WR_IN ? s_r.a_in : a_live;
      wb = b_live;
      if (REG_RADDR) begin
         wb.addr = c_r.b_in.addr;
         wb.rden = c_r.b_in.rden;
      end
      if (REG_WR_IN) begin
         wb.din = c_r.b_in.din;
         wb.we = c_r.b_in.we;
         wb.be = c_r.b_in.be;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      for (int k = 0; k < RATIO; k++) begin
         if (eb_in && wb.we) begin
            mem[lane(wb.addr, k)] <= wr_word(mem[lane(wb.addr, k)], wb.din[k*A_W +: A_W],
                                             wb.be[k*NBA +: NBA], '0, 1'b0);
         end
      end
      // Port A is applied last, so it wins a same-address collision.
      if (ea_in && wa.we) begin
         mem[wa.addr] <= wr_word(mem[wa.addr], wa.din, wa.be, wa.chk, byp);
      end
   end

   always_comb begin
      qa_word = mem[wa.addr];
      qa_pre = qa_word[A_W-1:0];
      coh_q_a_o = COHERENT_EN ? qa_pre : '0;
   end

   always_comb begin
      logic [CW-1:0] w;
      logic [AAW-1:0] la;
      w = '0;
      la = '0;
      rb_cw = '0;
      for (int k = 0; k < RATIO; k++) begin
         la = lane(wb.addr, k);
         w = mem[la];
         if (s_r.ctrl.rdw_new && ea_in && wa.we && wa.addr == la) begin
            w = wr_word(w, wa.din, wa.be, wa.chk, byp);
         end
         if (ECC_EN) begin
            rb_cw = CWB'(w);
         end else begin
            rb_cw[k*A_W +: A_W] = w[A_W-1:0];
         end
      end
   end

   always_comb begin
      dec_in = ECC_PIPE ? c_r.pipe : rb_cw;
      rden_dec = ECC_PIPE ? c_r.pipe_rden : wb.rden;
      dx = ecc_dec((3*A_W)'(dec_in));
      qb_pre = ECC_EN ? B_W'(dx[A_W-1:0]) : B_W'(dec_in);
      dcorr = ECC_EN & dx[A_W];
      duncorr = ECC_EN & dx[A_W+1];
   end

   always_comb begin
      logic [1:0] set, clr;
      set = '0;
      clr = '0;
      s_nxt = s_r;
      c_nxt = c_r;
      if (ea_in) begin
         s_nxt.a_in = a_live;
         if (ADDR_STALL_EN && addr_stall_a_i) begin
            s_nxt.a_in.addr = s_r.a_in.addr;
         end
      end
      if (eb_in) begin
         c_nxt.b_in = b_live;
         if (ADDR_STALL_EN && addr_stall_b_i) begin
            c_nxt.b_in.addr = c_r.b_in.addr;
         end
      end
      if (eb_out) begin
         c_nxt.pipe = rb_cw;
         c_nxt.pipe_rden = wb.rden;
      end
      if (SCLR_EN && sclr_i) begin
         c_nxt.q_a = '0;
      end else if (ea_out) begin
         if (wa.rden) begin
            c_nxt.q_a = qa_pre;
         end else if (fz) begin
            c_nxt.q_a = '0;
         end
      end
      if (SCLR_EN && sclr_i) begin
         c_nxt.q_b = '0;
         c_nxt.corr = 1'b0;
         c_nxt.uncorr = 1'b0;
      end else if (eb_out) begin
         if (rden_dec) begin
            c_nxt.q_b = qb_pre;
            c_nxt.corr = dcorr;
            c_nxt.uncorr = duncorr;
         end else if (fz) begin
            c_nxt.q_b = '0;
         end
      end
      if (eb_out && rden_dec) begin
         set[ctpr_pkg::STAT_CORR] = dcorr;
         set[ctpr_pkg::STAT_UNCORR] = duncorr;
      end
      if (apb_wr && hit_stat) begin
         clr = pwdata_i[1:0];
      end
      s_nxt.stat = (s_r.stat & ~clr) | set;
      if (apb_wr && hit_ctrl) begin
         s_nxt.ctrl = ctpr_pkg::ctpr_ctrl_t'(pwdata_i[ctpr_pkg::CTRL_W-1:0]);
      end
      if (psel_i && !penable_i) begin
         s_nxt.prdata = hit_ctrl ? 32'(s_r.ctrl) : hit_stat ? 32'(s_r.stat) : '0;
      end
   end

   assign hit_ctrl = paddr_i == ctpr_pkg::CTRL_OFS;
   assign hit_stat = paddr_i == ctpr_pkg::STAT_OFS;
   assign apb_wr = psel_i & penable_i & pwrite_i;
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~(hit_ctrl | hit_stat);
   assign prdata_o = s_r.prdata;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_r <= '0;
         s_r.ctrl <= ctpr_pkg::CTRL_RST;
         s_r.stat <= ctpr_pkg::STAT_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n) begin
      if (!arst_n) begin
         c_r <= '0;
      end else begin
         c_r <= c_nxt;
      end
   end

   // Unregistered outputs cannot hold, so without force-to-zero they follow the array.
   always_comb begin
      q_a_o = '0;
      if (TRUE_TWO_PORT) begin
         q_a_o = REG_QA ? c_r.q_a : ((fz && !wa.rden) ? '0 : qa_pre);
      end
      q_b_o = REG_QB ? c_r.q_b : ((fz && !rden_dec) ? '0 : qb_pre);
      ecc_corr_o = REG_QB ? c_r.corr : dcorr;
      ecc_uncorr_o = REG_QB ? c_r.uncorr : duncorr;
   end

   // The decoder input is widened first so all three copies can be sliced in every build.
   logic [3*A_W-1:0] dec3;
   logic [A_W-1:0] e0, e1, e2;
   assign dec3 = (3*A_W)'(dec_in);
   assign e0 = dec3[A_W-1:0];
   assign e1 = dec3[A_W +: A_W];
   assign e2 = dec3[2*A_W +: A_W];
   logic b_wr;
   assign b_wr = eb_in & wb.we;

   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   sclr_clear_a: assert property (SCLR_EN && REG_QB && sclr_i && !aclr_i |=> q_b_o == '0)
      else $error("Sync clear did not zero q_b.");
   fz_out_a: assert property (REG_QB && !sclr_i && eb_out && !rden_dec && fz |=> q_b_o == '0)
      else $error("Force-to-zero output not zero.");
   out_hold_a: assert property (REG_QB && !sclr_i && !eb_out && !aclr_i
      |=> $stable(q_b_o) || aclr_i)
      else $error("Output changed without its enable.");
   rd_capture_a: assert property (REG_QB && !sclr_i && !aclr_i && eb_out && rden_dec
      |=> q_b_o == $past(qb_pre) || aclr_i)
      else $error("Enabled read not captured.");
   stall_hold_a: assert property (REG_WR_IN && ADDR_STALL_EN && addr_stall_a_i
      |=> s_r.a_in.addr == $past(s_r.a_in.addr))
      else $error("Stalled address register moved.");
   wr_store_a: assert property (!ECC_EN && ea_in && wa.we && (&wa.be) && !b_wr
      |=> mem[$past(wa.addr)][A_W-1:0] == $past(wa.din))
      else $error("Enabled write not stored.");
   be_mask_a: assert property (BE_A_EN && ea_in && wa.we && !wa.be[0] && !b_wr
      |=> mem[$past(wa.addr)][BYTE_W-1:0] == $past(qa_pre[BYTE_W-1:0]))
      else $error("Masked byte was overwritten.");
   rdw_new_a: assert property (!ECC_EN && RATIO == 1 && s_r.ctrl.rdw_new && ea_in && wa.we
      && (&wa.be) && wa.addr == AAW'(wb.addr) |-> rb_cw[A_W-1:0] == wa.din)
      else $error("Collision did not show new data.");
   rdw_old_a: assert property (!ECC_EN && RATIO == 1 && !s_r.ctrl.rdw_new && ea_in && wa.we
      && wa.addr == AAW'(wb.addr) |-> rb_cw[A_W-1:0] == qa_pre)
      else $error("Collision did not show old data.");
   ecc_fix_a: assert property (ECC_EN && e1 == e2 && e0 != e1
      |-> qb_pre == B_W'(e1) && dcorr && !duncorr)
      else $error("Single-copy error not corrected.");
   sticky_set_a: assert property (ECC_EN && eb_out && rden_dec && duncorr
      |=> s_r.stat[ctpr_pkg::STAT_UNCORR])
      else $error("Uncorrectable event not recorded.");

   wr_then_rd_c: cover property (ea_in && wa.we ##1 eb_out && rden_dec);
   ecc_corr_c: cover property (ECC_EN && eb_out && rden_dec && dcorr);
   fz_c: cover property (fz && eb_out && !rden_dec);
   rdw_c: cover property (ea_in && wa.we && wa.addr == lane(wb.addr, 0));

endmodule

/* File: verification/ctpr_fabric.sv */
/*
 Behavioural model of the user fabric logic that drives both memory ports.
 Assumes one clock shared with the memory, equal port widths and the default
 registered write inputs, so a write lands two edges after it is presented.
*/
`timescale 1ns/1ns
module ctpr_fabric #(
   parameter int A_W = 16,
   parameter int B_W = 16,
   parameter int DEPTH = 256,
   parameter int BYTE_W = 8
) (
   input wire logic ref_clk_i,
   input wire logic [B_W-1:0] q_b_i,
   output logic [$clog2(DEPTH)-1:0] addr_a_o,
   output logic [A_W-1:0] data_a_o,
   output logic we_a_o,
   output logic [A_W/BYTE_W-1:0] be_a_o,
   output logic rden_a_o,
   output logic [$clog2(DEPTH*A_W/B_W)-1:0] addr_b_o,
   output logic [B_W-1:0] data_b_o,
   output logic we_b_o,
   output logic [B_W/BYTE_W-1:0] be_b_o,
   output logic rden_b_o
);
   localparam int AW = $clog2(DEPTH);
   localparam int BAW = $clog2(DEPTH*A_W/B_W);
   localparam int NB = A_W/BYTE_W;

   // width ratio kept. no pipeline without ECC. one clock only.
   initial begin
      addr_a_o = '0;
      data_a_o = '0;
      we_a_o = 1'b0;
      be_a_o = '0;
      rden_a_o = 1'b0;
      addr_b_o = '0;
      data_b_o = '0;
      we_b_o = 1'b0;
      be_b_o = '0;
      rden_b_o = 1'b0;
   end

   // Released write lines carry the inverse so a stale value cannot pass.
   task automatic write(input logic [AW-1:0] a, input logic [A_W-1:0] d,
         input logic [NB-1:0] be);
      @(posedge ref_clk_i);
      addr_a_o <= a;
      data_a_o <= d;
      be_a_o <= be;
      we_a_o <= 1'b1;
      @(posedge ref_clk_i);
      we_a_o <= 1'b0;
      data_a_o <= ~d;
      be_a_o <= ~be;
      @(posedge ref_clk_i);
   endtask

   // Address is driven at the first edge, registered at the second and data captured at the third.
   task automatic read(input logic [BAW-1:0] a, input logic re, output logic [B_W-1:0] q);
      @(posedge ref_clk_i);
      addr_b_o <= a;
      rden_b_o <= re;
      @(posedge ref_clk_i);
      @(posedge ref_clk_i);
      #1;
      q = q_b_i;
   endtask
endmodule

/* File: verification/tb.sv */
/*
 Self-checking bench for the two-port RAM in its default simple dual-port,
 single-clock build: APB control registers, writes, masked writes, enables,
 stalls and clears. Assumes the fabric model in ctpr_fabric drives the ports.
*/
`timescale 1ns/1ns
module tb;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic aclr = 1'b0;
   logic sclr = 1'b0;
   logic clken_in = 1'b1;
   logic clken_keep = 1'b1;
   logic stall_a = 1'b0;
   logic stall_b = 1'b0;
   logic [ctpr_pkg::APB_AW-1:0] paddr = '0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, err;
   logic [15:0] q_a, q_b, data_a, data_b, q;
   logic [7:0] addr_a, addr_b;
   logic we_a, we_b, rden_a, rden_b;
   logic [1:0] be_a, be_b;
   logic [31:0] rd;
   int mismatches = 0;
   int cmp_count = 0;

   always #10 ref_clk_i = ~ref_clk_i;

   ctpr_fabric fab (.ref_clk_i(ref_clk_i), .q_b_i(q_b), .addr_a_o(addr_a), .data_a_o(data_a),
      .we_a_o(we_a), .be_a_o(be_a), .rden_a_o(rden_a), .addr_b_o(addr_b), .data_b_o(data_b),
      .we_b_o(we_b), .be_b_o(be_b), .rden_b_o(rden_b));

   ctpr_ram DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .aclr_i(aclr), .sclr_i(sclr),
      .clken_a_in_i(clken_in), .clken_a_out_i(clken_keep), .clken_b_in_i(clken_keep),
      .clken_b_out_i(clken_keep), .addr_stall_a_i(stall_a), .addr_stall_b_i(stall_b),
      .addr_a_i(addr_a), .data_a_i(data_a), .we_a_i(we_a), .be_a_i(be_a), .rden_a_i(rden_a),
      .ecc_chk_a_i(32'h0), .q_a_o(q_a), .coh_q_a_o(), .addr_b_i(addr_b), .data_b_i(data_b),
      .we_b_i(we_b), .be_b_i(be_b), .rden_b_i(rden_b), .q_b_o(q_b), .ecc_corr_o(),
      .ecc_uncorr_o(), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr));

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // The request is held until pready is sampled high; only the watchdog ends a wait.
   task automatic apb(input logic [ctpr_pkg::APB_AW-1:0] a, input logic w, input logic [31:0] d);
      @(posedge ref_clk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge ref_clk_i);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk_i);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      #100000;
      mismatches++;
      conclude();
   end

   initial begin
      repeat (2) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      apb(ctpr_pkg::CTRL_OFS, 1'b0, 32'h0);
      check("ctrl_rst", rd, 32'h0);
      for (int i = 0; i < ctpr_pkg::CTRL_W; i++) begin
         apb(ctpr_pkg::CTRL_OFS, 1'b1, 32'h1 << i);
         apb(ctpr_pkg::CTRL_OFS, 1'b0, 32'h0);
         check("ctrl_bit", rd, 32'h1 << i);
      end
      apb(ctpr_pkg::CTRL_OFS, 1'b1, 32'h0);
      apb(12'h008, 1'b0, 32'h0);
      check("unmapped_err", {31'h0, err}, 32'h1);
      check("unmapped_data", rd, 32'h0);
      // status is clear without ECC events.
      apb(ctpr_pkg::STAT_OFS, 1'b1, 32'h3);
      apb(ctpr_pkg::STAT_OFS, 1'b0, 32'h0);
      check("stat", rd, 32'h0);
      fab.write(8'h05, 16'hA5C3, 2'h3);
      fab.write(8'h06, 16'h5A3C, 2'h3);
      fab.write(8'h07, 16'h0F0F, 2'h3);
      fab.read(8'h05, 1'b1, q);
      check("rd_basic", q, 16'hA5C3);
      check("q_a_zero", q_a, 16'h0);
      fab.write(8'h09, 16'h1234, 2'h3);
      fab.write(8'h09, 16'hABCD, 2'h1);
      fab.write(8'h09, 16'hFFFF, 2'h0);
      fab.read(8'h09, 1'b1, q);
      check("be_mask", q, 16'h12CD);
      // a stalled port A address keeps the write at the old location.
      @(posedge ref_clk_i);
      stall_a <= 1'b1;
      fab.write(8'h0A, 16'h1111, 2'h3);
      stall_a <= 1'b0;
      fab.read(8'h09, 1'b1, q);
      check("stall_a", q, 16'h1111);
      @(posedge ref_clk_i);
      clken_in <= 1'b0;
      fab.write(8'h07, 16'hFFFF, 2'h3);
      @(posedge ref_clk_i);
      clken_in <= 1'b1;
      fab.read(8'h07, 1'b1, q);
      check("clken_off", q, 16'h0F0F);
      fab.read(8'h06, 1'b1, q);
      fab.read(8'h05, 1'b0, q);
      check("rden_hold", q, 16'h5A3C);
      // force to zero when not reading.
      apb(ctpr_pkg::CTRL_OFS, 1'b1, 32'h2);
      fab.read(8'h05, 1'b0, q);
      check("force_zero", q, 16'h0);
      apb(ctpr_pkg::CTRL_OFS, 1'b1, 32'h0);
      fab.read(8'h05, 1'b1, q);
      @(posedge ref_clk_i);
      stall_b <= 1'b1;
      fab.read(8'h06, 1'b1, q);
      check("stall_hold", q, 16'hA5C3);
      @(posedge ref_clk_i);
      stall_b <= 1'b0;
      fab.read(8'h06, 1'b1, q);
      check("stall_free", q, 16'h5A3C);
      // a same-cycle collision shows old data, then new data once selected.
      for (int i = 0; i < 2; i++) begin
         apb(ctpr_pkg::CTRL_OFS, 1'b1, 32'(i));
         fork
            fab.write(8'h06, i ? 16'hC33D : 16'hC33C, 2'h3);
            fab.read(8'h06, 1'b1, q);
         join
         check("rdw", q, i ? 16'hC33D : 16'h5A3C);
      end
      // asynchronous clear acts before any edge.
      @(posedge ref_clk_i);
      aclr <= 1'b1;
      #1;
      check("aclr_q", q_b, 16'h0);
      @(posedge ref_clk_i);
      aclr <= 1'b0;
      // synchronous clear acts on the edge.
      fab.read(8'h06, 1'b1, q);
      @(posedge ref_clk_i);
      sclr <= 1'b1;
      @(posedge ref_clk_i);
      #1;
      check("sclr_q", q_b, 16'h0);
      @(posedge ref_clk_i);
      sclr <= 1'b0;
      conclude();
   end
endmodule
